// ---- common/ckg_pkg.sv ----
// Package for the clock control register block
// Overview of operation
// - Security and switch events raise interrupt requests, each gated by an enable
// - System clock divided by two to the prescale code; reset code 3
// - RTC clock divided by two to the RTC divider code
// - RTC source chosen by one-hot four-bit code, zero means none
// - Writes with undefined RTC source codes are skipped; all eight divider codes are accepted
// - RTC divider and source frozen while RTC switch busy is set
// - Busy flag set on valid RTC change, cleared when change completes
// - RTC clock register cleared only at power-on, kept over system reset
// - Internal clock register loads 0x11 on reset
// - Beeper clock runs in halt only when beep-in-halt bit set
// - Fast wakeup leaves halt on fast internal oscillator divided by 8
// - Slow-halt bit powers off main regulator in active-halt
// - Oscillator ready flags follow hardware, read only
// - Slow internal enable forced on whenever that oscillator is needed
// - Software clear of slow internal enable refused while in use
// - Fast internal enable forced on whenever that oscillator is needed
// - Software clear of fast internal enable refused while in use
// - Bank one gating: eight enables, reset 0x00, 1 passes clock
// - Bank two gating: bit 7 boot ROM, bit 6 reserved, reset 0x80
// - RTC register access clock gated by bank two bit 2
package ckg_pkg;
    localparam logic [2:0] ADDR_SYS_DIV    = 3'h0;
    localparam logic [2:0] ADDR_RTC_SEL    = 3'h1;
    localparam logic [2:0] ADDR_INT_OSC    = 3'h2;
    localparam logic [2:0] ADDR_GATE_ONE   = 3'h3;
    localparam logic [2:0] ADDR_GATE_TWO   = 3'h4;
    localparam logic [2:0] ADDR_IRQ_CTRL   = 3'h5;
    localparam logic [7:0] RST_SYS_DIV     = 8'h03;
    localparam logic [7:0] RST_RTC_SEL     = 8'h00;
    localparam logic [7:0] RST_INT_OSC     = 8'h11;
    localparam logic [7:0] RST_GATE_ONE    = 8'h00;
    localparam logic [7:0] RST_GATE_TWO    = 8'h80;
    localparam logic [7:0] MASK_SYS_DIV    = 8'h07;
    localparam logic [7:0] MASK_INT_OSC    = 8'h75;
    localparam logic [7:0] MASK_GATE_TWO   = 8'hBF;
    localparam int BIT_BEEP_HALT   = 6;
    localparam int BIT_FAST_WAKE   = 5;
    localparam int BIT_SLOW_HALT   = 4;
    localparam int BIT_SLOW_RDY    = 3;
    localparam int BIT_SLOW_EN     = 2;
    localparam int BIT_FAST_RDY    = 1;
    localparam int BIT_FAST_EN     = 0;
    localparam int BIT_RTC_GATE    = 2;
    localparam int BIT_BOOT_GATE   = 7;
    localparam logic [3:0] SRC_NONE = 4'h0;
    localparam logic [3:0] SRC_FINT = 4'h1;
    localparam logic [3:0] SRC_SINT = 4'h2;
    localparam logic [3:0] SRC_FEXT = 4'h4;
    localparam logic [3:0] SRC_SEXT = 4'h8;
    localparam int WAKE_DIV_LOG2   = 3;
    localparam int RTC_SW_CYCLES   = 4;

    typedef struct packed {
        logic sys_is_sint;
        logic sys_is_fint;
        logic sw_to_sint;
        logic sw_to_fint;
        logic cco_is_sint;
        logic cco_is_fint;
        logic beep_is_sint;
        logic osc_measure_enable;
        logic safe_osc_on;
        logic halt_wake_fast;
    } ckg_need_t;

    typedef struct packed {
        logic beeper_clk_run;
        logic regulator_off;
        logic wake_on_fast;
    } ckg_halt_t;
endpackage

// ---- logic/ckg_regs.sv ----
// Clock control register block on an Avalon-MM slave
//
// Chosen here: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none
module ckg_regs (
    input  wire logic              i_ref_clk,
    input  wire logic              i_rst_n,
    input  wire logic              i_por_n,
    input  wire logic [2:0]        i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    output logic [31:0]            o_avs_readdata,
    output logic                   o_avs_waitrequest,
    input  wire ckg_pkg::ckg_need_t i_need,
    input  wire logic              i_slow_rdy_pin,
    input  wire logic              i_fast_rdy_pin,
    input  wire logic              i_security_event,
    input  wire logic              i_switch_event,
    input  wire logic              i_halt_active,
    input  wire logic              i_in_active_halt,
    output logic [7:0]             o_sys_div_ratio_log2,
    output logic [2:0]             o_rtc_div_log2,
    output logic [3:0]             o_rtc_source,
    output logic                   o_slow_internal_enable,
    output logic                   o_fast_internal_enable,
    output ckg_pkg::ckg_halt_t     o_halt,
    output logic [7:0]             o_gate_bank_one,
    output logic [7:0]             o_gate_bank_two,
    output logic                   o_rtc_reg_clk_en,
    output logic                   o_security_irq,
    output logic                   o_switch_irq
);
    import ckg_pkg::*;

    logic [7:0] sys_div_r;
    logic [2:0] rtc_div_r;
    logic [3:0] rtc_src_r;
    logic       rtc_busy_r;
    logic [2:0] rtc_cnt_r;
    logic [7:0] int_osc_r;
    logic [7:0] gate_one_r;
    logic [7:0] gate_two_r;
    logic       sec_flag_r;
    logic       sw_flag_r;
    logic       sec_ie_r;
    logic       sw_ie_r;
    logic [2:0] slow_sync_r;
    logic [2:0] fast_sync_r;
    logic       slow_rdy_r;
    logic       fast_rdy_r;
    logic       ack_r;
    logic       waitreq_r;
    logic       irq_wr;
    logic [31:0] rdata_r;
    logic       wr_hit;
    logic [7:0] wd;
    logic       src_ok;
    logic       slow_need;
    logic       fast_need;
    logic       slow_keep;
    logic       fast_keep;

    assign wd     = i_avs_writedata[7:0];
    // Single wait cycle, then acknowledge
    assign wr_hit = i_avs_write && ack_r;
    assign irq_wr = wr_hit && (i_avs_address == ADDR_IRQ_CTRL);
    assign src_ok = (wd[4:1] == SRC_NONE) || (wd[4:1] == SRC_FINT) ||
                    (wd[4:1] == SRC_SINT) || (wd[4:1] == SRC_FEXT) ||
                    (wd[4:1] == SRC_SEXT);

    // Forcing and clear protection for internal oscillators
    assign slow_need = i_need.sw_to_sint || i_need.cco_is_sint ||
                       (rtc_src_r == SRC_SINT) || i_need.beep_is_sint ||
                       i_need.osc_measure_enable;
    assign slow_keep = i_need.sys_is_sint || i_need.cco_is_sint ||
                       (rtc_src_r == SRC_SINT) ||
                       (i_need.beep_is_sint && int_osc_r[BIT_BEEP_HALT]);
    assign fast_need = i_need.safe_osc_on || i_need.sw_to_fint ||
                       i_need.cco_is_fint || (rtc_src_r == SRC_FINT) ||
                       (i_need.halt_wake_fast && int_osc_r[BIT_FAST_WAKE]);
    assign fast_keep = i_need.sys_is_fint || i_need.cco_is_fint ||
                       (rtc_src_r == SRC_FINT) || i_need.safe_osc_on;

    // Bus handshake
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            ack_r     <= 1'b0;
            waitreq_r <= 1'b1;
        end else begin
            ack_r     <= (i_avs_read || i_avs_write) && !ack_r;
            // Registered copy so the pin comes straight from a flop
            waitreq_r <= !((i_avs_read || i_avs_write) && !ack_r);
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            rdata_r <= 32'h0000_0000;
        end else if (i_avs_read && !ack_r) begin
            case (i_avs_address)
                ADDR_SYS_DIV:  rdata_r <= {24'h0, sys_div_r};
                ADDR_RTC_SEL:  rdata_r <= {24'h0, rtc_div_r, rtc_src_r,
                                           rtc_busy_r};
                ADDR_INT_OSC:  rdata_r <= {24'h0, int_osc_r[7:4], slow_rdy_r,
                                           int_osc_r[2], fast_rdy_r,
                                           int_osc_r[0]};
                ADDR_GATE_ONE: rdata_r <= {24'h0, gate_one_r};
                ADDR_GATE_TWO: rdata_r <= {24'h0, gate_two_r};
                ADDR_IRQ_CTRL: rdata_r <= {28'h0, sw_flag_r, sw_ie_r,
                                           sec_flag_r, sec_ie_r};
                default:       rdata_r <= 32'h0000_0000;
            endcase
        end
    end

    // System prescaler
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sys_div_r <= RST_SYS_DIV;
        end else if (wr_hit && i_avs_address == ADDR_SYS_DIV) begin
            sys_div_r <= wd & MASK_SYS_DIV;
        end
    end

    // RTC select lives on power-on reset only, survives system reset
    always_ff @(posedge i_ref_clk or negedge i_por_n) begin
        if (!i_por_n) begin
            rtc_div_r  <= RST_RTC_SEL[7:5];
            rtc_src_r  <= RST_RTC_SEL[4:1];
            rtc_busy_r <= RST_RTC_SEL[0];
            rtc_cnt_r  <= 3'h0;
        end else if (rtc_busy_r) begin
            // Change procedure settles over a fixed number of cycles
            if (rtc_cnt_r == 3'(RTC_SW_CYCLES - 1)) begin
                rtc_busy_r <= 1'b0;
                rtc_cnt_r  <= 3'h0;
            end else begin
                rtc_cnt_r <= rtc_cnt_r + 3'h1;
            end
        end else if (wr_hit && i_avs_address == ADDR_RTC_SEL && src_ok) begin
            rtc_div_r <= wd[7:5];
            rtc_src_r <= wd[4:1];
            if (wd[7:5] != rtc_div_r || wd[4:1] != rtc_src_r) begin
                rtc_busy_r <= 1'b1;
            end
        end
    end

    // Internal oscillator control
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            int_osc_r <= RST_INT_OSC;
        end else begin
            if (wr_hit && i_avs_address == ADDR_INT_OSC) begin
                int_osc_r[6:4] <= wd[6:4];
                int_osc_r[BIT_SLOW_EN] <= wd[BIT_SLOW_EN] || slow_keep ||
                                          slow_need;
                int_osc_r[BIT_FAST_EN] <= wd[BIT_FAST_EN] || fast_keep ||
                                          fast_need;
            end else begin
                int_osc_r[BIT_SLOW_EN] <= int_osc_r[BIT_SLOW_EN] ||
                                          slow_need;
                int_osc_r[BIT_FAST_EN] <= int_osc_r[BIT_FAST_EN] ||
                                          fast_need;
            end
            int_osc_r[7] <= 1'b0;
            int_osc_r[BIT_SLOW_RDY] <= 1'b0;
            int_osc_r[BIT_FAST_RDY] <= 1'b0;
        end
    end

    // Ready pins come from the analog side: three-stage sync
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            slow_sync_r <= 3'h0;
            fast_sync_r <= 3'h0;
            slow_rdy_r  <= 1'b0;
            fast_rdy_r  <= 1'b0;
        end else begin
            slow_sync_r <= {slow_sync_r[1:0], i_slow_rdy_pin};
            fast_sync_r <= {fast_sync_r[1:0], i_fast_rdy_pin};
            if (slow_sync_r[1] == slow_sync_r[2]) begin
                slow_rdy_r <= slow_sync_r[2];
            end
            if (fast_sync_r[1] == fast_sync_r[2]) begin
                fast_rdy_r <= fast_sync_r[2];
            end
        end
    end

    // Peripheral gating banks
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            gate_one_r <= RST_GATE_ONE;
            gate_two_r <= RST_GATE_TWO;
        end else if (wr_hit && i_avs_address == ADDR_GATE_ONE) begin
            gate_one_r <= wd;
        end else if (wr_hit && i_avs_address == ADDR_GATE_TWO) begin
            gate_two_r <= wd & MASK_GATE_TWO;
        end
    end

    // Interrupt flags: hardware set beats software clear
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            sec_flag_r <= 1'b0;
            sw_flag_r  <= 1'b0;
            sec_ie_r   <= 1'b0;
            sw_ie_r    <= 1'b0;
        end else begin
            if (irq_wr) begin
                sec_ie_r <= wd[0];
                sw_ie_r  <= wd[2];
            end
            if (i_security_event) begin
                sec_flag_r <= 1'b1;
            end else if (irq_wr && !wd[1]) begin
                sec_flag_r <= 1'b0;
            end
            if (i_switch_event) begin
                sw_flag_r <= 1'b1;
            end else if (irq_wr && !wd[3]) begin
                sw_flag_r <= 1'b0;
            end
        end
    end

    // Registered outputs
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_sys_div_ratio_log2   <= 8'h00;
            o_rtc_div_log2         <= 3'h0;
            o_rtc_source           <= 4'h0;
            o_slow_internal_enable <= 1'b0;
            o_fast_internal_enable <= 1'b0;
            o_halt                 <= '0;
            o_gate_bank_one        <= 8'h00;
            o_gate_bank_two        <= 8'h00;
            o_rtc_reg_clk_en       <= 1'b0;
            o_security_irq         <= 1'b0;
            o_switch_irq           <= 1'b0;
        end else begin
            o_sys_div_ratio_log2   <= sys_div_r;
            o_rtc_div_log2         <= rtc_div_r;
            o_rtc_source           <= rtc_src_r;
            o_slow_internal_enable <= int_osc_r[BIT_SLOW_EN];
            o_fast_internal_enable <= int_osc_r[BIT_FAST_EN];
            // Bit covers halt and active-halt alike
            o_halt.beeper_clk_run  <= !i_halt_active ||
                                      int_osc_r[BIT_BEEP_HALT];
            o_halt.regulator_off   <= i_in_active_halt &&
                                      int_osc_r[BIT_SLOW_HALT];
            o_halt.wake_on_fast    <= int_osc_r[BIT_FAST_WAKE];
            o_gate_bank_one        <= gate_one_r;
            o_gate_bank_two        <= gate_two_r;
            o_rtc_reg_clk_en       <= gate_two_r[BIT_RTC_GATE];
            // Wake from wait only; halt wake is left to the power block
            o_security_irq         <= sec_flag_r && sec_ie_r &&
                                      !i_halt_active;
            o_switch_irq           <= sw_flag_r && sw_ie_r &&
                                      !i_halt_active;
        end
    end

    assign o_avs_readdata    = rdata_r;
    assign o_avs_waitrequest = waitreq_r;

    a_rtc_busy_freeze: assert property (@(posedge i_ref_clk)
        disable iff (!i_por_n)
        rtc_busy_r |=> $stable(rtc_src_r) && $stable(rtc_div_r))
        else $error("rtc fields changed while busy");
    a_rtc_bad_code: assert property (@(posedge i_ref_clk)
        disable iff (!i_por_n)
        (wr_hit && i_avs_address == ADDR_RTC_SEL && !src_ok)
            |=> $stable(rtc_src_r))
        else $error("invalid rtc code accepted");
    a_rtc_busy_ends: assert property (@(posedge i_ref_clk)
        disable iff (!i_por_n)
        $rose(rtc_busy_r) |-> ##[1:4] !rtc_busy_r)
        else $error("rtc busy did not clear");
    a_slow_forced: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        slow_need |=> int_osc_r[BIT_SLOW_EN])
        else $error("slow enable not forced");
    a_slow_keep: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        (slow_keep && int_osc_r[BIT_SLOW_EN]) |=> int_osc_r[BIT_SLOW_EN])
        else $error("slow enable cleared while used");
    a_fast_forced: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        fast_need |=> int_osc_r[BIT_FAST_EN])
        else $error("fast enable not forced");
    a_fast_keep: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        (fast_keep && int_osc_r[BIT_FAST_EN]) |=> int_osc_r[BIT_FAST_EN])
        else $error("fast enable cleared while used");
    a_sec_irq_gate: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        o_security_irq |-> $past(sec_ie_r))
        else $error("security irq without enable");
    a_irq_halt_mask: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        i_halt_active |=> !o_security_irq && !o_switch_irq)
        else $error("irq raised in halt");
    a_flag_set_wins: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        i_switch_event |=> sw_flag_r)
        else $error("switch flag lost");
    a_beep_stop: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        (i_halt_active && !int_osc_r[BIT_BEEP_HALT])
            |=> !o_halt.beeper_clk_run)
        else $error("beeper clock ran in halt");
    a_regulator_on: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        !int_osc_r[BIT_SLOW_HALT] |=> !o_halt.regulator_off)
        else $error("regulator off without slow halt");
    a_rtc_gate_follow: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        ##1 o_rtc_reg_clk_en == $past(gate_two_r[BIT_RTC_GATE]))
        else $error("rtc access gate mismatch");
    a_gate_two_rsvd: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        !gate_two_r[6])
        else $error("reserved gate bit set");
    a_sys_div_rsvd: assert property (@(posedge i_ref_clk)
        disable iff (!i_rst_n)
        sys_div_r[7:3] == 5'h00)
        else $error("reserved divider bits set");
endmodule
`default_nettype wire

// ---- tb/ckg_regs_tb.sv ----
// Self-checking bench for the clock control register block
`timescale 1ns/1ps
`default_nettype none
module ckg_regs_tb;
    import ckg_pkg::*;
    localparam logic [9:0] SLOW_NEED = 10'h2AC;
    localparam logic [9:0] FAST_NEED = 10'h153;
    logic        clk;
    logic        rst_n;
    logic        por_n;
    logic [2:0]  addr;
    logic        rd;
    logic        wr;
    logic [31:0] wdata;
    logic [31:0] rdata;
    logic        waitreq;
    ckg_need_t   need;
    logic        slow_rdy;
    logic        fast_rdy;
    logic        sec_ev;
    logic        sw_ev;
    logic        halt;
    logic        ahalt;
    logic [7:0]  div_o;
    logic [2:0]  rtc_div_o;
    logic [3:0]  rtc_src_o;
    logic        slow_en_o;
    logic        fast_en_o;
    ckg_halt_t   halt_o;
    logic [7:0]  gate1_o;
    logic [7:0]  gate2_o;
    logic        rtc_clk_o;
    logic        sec_irq;
    logic        sw_irq;
    int          fails;
    int          comparisons;
    logic [7:0]  v;
    logic [7:0]  rtc_exp;

    ckg_regs u_dut (
        .i_ref_clk(clk), .i_rst_n(rst_n), .i_por_n(por_n),
        .i_avs_address(addr), .i_avs_read(rd), .i_avs_write(wr),
        .i_avs_writedata(wdata), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .i_need(need),
        .i_slow_rdy_pin(slow_rdy), .i_fast_rdy_pin(fast_rdy),
        .i_security_event(sec_ev), .i_switch_event(sw_ev),
        .i_halt_active(halt), .i_in_active_halt(ahalt),
        .o_sys_div_ratio_log2(div_o), .o_rtc_div_log2(rtc_div_o),
        .o_rtc_source(rtc_src_o), .o_slow_internal_enable(slow_en_o),
        .o_fast_internal_enable(fast_en_o), .o_halt(halt_o),
        .o_gate_bank_one(gate1_o), .o_gate_bank_two(gate2_o),
        .o_rtc_reg_clk_en(rtc_clk_o), .o_security_irq(sec_irq),
        .o_switch_irq(sw_irq)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic stop_test;
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("BAD %s exp %h got %h", nm, exp, got);
        end
    endtask

    // Request held until waitrequest is sampled low, no fixed latency
    task automatic bus(input logic w, input logic [2:0] a,
                       input logic [7:0] d, output logic [31:0] r);
        @(posedge clk);
        addr  <= a;
        wr    <= w;
        rd    <= !w;
        wdata <= {24'h0, d};
        // A hung slave is ended by the watchdog
        do begin
            @(posedge clk);
        end while (waitreq !== 1'b0);
        r = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
    endtask

    task automatic wreg(input logic [2:0] a, input logic [7:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask

    task automatic rchk(input string nm, input logic [2:0] a,
                        input logic [7:0] e);
        logic [31:0] r;
        bus(1'b0, a, 8'h00, r);
        chk(nm, r, e);
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    function automatic logic [7:0] rtc_next(input logic [7:0] cur,
                                            input logic [7:0] d);
        if (d[4:1] inside {SRC_NONE, SRC_FINT, SRC_SINT, SRC_FEXT, SRC_SEXT})
            return {d[7:1], 1'b0};
        return cur;
    endfunction

    // Ready bits follow the pins, not the written value
    function automatic logic [7:0] osc_exp(input logic [7:0] d);
        return (d & MASK_INT_OSC) | {4'h0, slow_rdy, 1'b0, fast_rdy, 1'b0};
    endfunction

    task automatic reset_vals(input logic [7:0] rtc_e);
        rchk("sys_div", ADDR_SYS_DIV, RST_SYS_DIV);
        rchk("rtc_sel", ADDR_RTC_SEL, rtc_e);
        rchk("int_osc", ADDR_INT_OSC, osc_exp(RST_INT_OSC));
        rchk("gate_one", ADDR_GATE_ONE, RST_GATE_ONE);
        rchk("gate_two", ADDR_GATE_TWO, RST_GATE_TWO);
    endtask

    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        stop_test();
    end

    initial begin
        rst_n = 1'b0;
        por_n = 1'b0;
        {addr, rd, wr, wdata, need} = '0;
        {slow_rdy, fast_rdy, sec_ev, sw_ev, halt, ahalt} = '0;
        fails = 0;
        comparisons = 0;
        void'($urandom(32'h8cac5c70));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        reset_vals(8'h00);
        for (int i = 0; i < 8; i++) begin
            v = 8'($urandom());
            v[2:0] = i[2:0];
            wreg(ADDR_SYS_DIV, v);
            rchk("sys_div", ADDR_SYS_DIV, v & MASK_SYS_DIV);
            chk("div_out", div_o, {5'h0, i[2:0]});
        end
        rtc_exp = 8'h00;
        for (int s = 0; s < 16; s++) begin
            v = {3'($urandom()), s[3:0], 1'b1};
            wreg(ADDR_RTC_SEL, v);
            rtc_exp = rtc_next(rtc_exp, v);
            idle(8);
            rchk("rtc_sel", ADDR_RTC_SEL, rtc_exp);
            chk("rtc_div", rtc_div_o, rtc_exp[7:5]);
            chk("rtc_src", rtc_src_o, rtc_exp[4:1]);
        end
        v = {~rtc_exp[7:5], SRC_SEXT, 1'b0};
        wreg(ADDR_RTC_SEL, v);
        rchk("rtc_busy", ADDR_RTC_SEL, v | 8'h01);
        idle(8);
        rchk("rtc_done", ADDR_RTC_SEL, v);
        rtc_exp = {3'h6, SRC_FINT, 1'b0};
        wreg(ADDR_RTC_SEL, rtc_exp);
        wreg(ADDR_RTC_SEL, {3'h1, SRC_SINT, 1'b0});
        idle(8);
        rchk("rtc_frozen", ADDR_RTC_SEL, rtc_exp);
        rst_n <= 1'b0;
        idle(3);
        rst_n <= 1'b1;
        reset_vals(rtc_exp);
        rst_n <= 1'b0;
        por_n <= 1'b0;
        idle(3);
        rst_n <= 1'b1;
        por_n <= 1'b1;
        rchk("rtc_por", ADDR_RTC_SEL, 8'h00);
        for (int i = 0; i < 10; i++) begin
            wreg(ADDR_INT_OSC, 8'h05);
            need <= ckg_need_t'(10'h1 << i);
            // Fast wakeup left on so a halt exit forces fast enable
            wreg(ADDR_INT_OSC, 8'h20);
            idle(3);
            chk("slow_en", slow_en_o, SLOW_NEED[i]);
            chk("fast_en", fast_en_o, FAST_NEED[i]);
            need <= '0;
        end
        for (int k = 0; k < 2; k++) begin
            wreg(ADDR_INT_OSC, 8'h05);
            wreg(ADDR_RTC_SEL, {3'h0, k ? SRC_FINT : SRC_SINT, 1'b0});
            idle(8);
            wreg(ADDR_INT_OSC, 8'h00);
            idle(3);
            chk("osc_rtc", {slow_en_o, fast_en_o}, 2 - k);
        end
        for (int i = 0; i < 8; i++) begin
            v = {1'b1, i[2:0], 4'h5};
            wreg(ADDR_INT_OSC, v);
            halt <= 1'b1;
            ahalt <= 1'b1;
            idle(3);
            chk("beep_run", halt_o.beeper_clk_run, v[6]);
            chk("reg_off", halt_o.regulator_off, v[4]);
            chk("wake_fast", halt_o.wake_on_fast, v[5]);
            rchk("int_osc", ADDR_INT_OSC, osc_exp(v));
        end
        halt <= 1'b0;
        ahalt <= 1'b0;
        for (int i = 0; i < 6; i++) begin
            v = (i == 0) ? 8'hFF : 8'($urandom());
            // Software drops the boot ROM gate on the last pass
            if (i == 5) v[BIT_BOOT_GATE] = 1'b0;
            wreg(ADDR_GATE_ONE, ~v);
            wreg(ADDR_GATE_TWO, v);
            idle(2);
            chk("gate_one", gate1_o, 8'(~v));
            chk("gate_two", gate2_o, v & MASK_GATE_TWO);
            chk("rtc_clk", rtc_clk_o, v[BIT_RTC_GATE]);
            rchk("gate_rd", ADDR_GATE_TWO, v & MASK_GATE_TWO);
        end
        for (int k = 0; k < 2; k++) begin
            wreg(ADDR_IRQ_CTRL, k ? 8'h04 : 8'h01);
            if (k) sw_ev <= 1'b1;
            else sec_ev <= 1'b1;
            @(posedge clk);
            sw_ev <= 1'b0;
            sec_ev <= 1'b0;
            idle(3);
            chk("irq_on", {sec_irq, sw_irq}, k ? 1 : 2);
            rchk("irq_flag", ADDR_IRQ_CTRL, k ? 8'h0C : 8'h03);
            halt <= 1'b1;
            idle(3);
            chk("irq_halt", {sec_irq, sw_irq}, 0);
            halt <= 1'b0;
            wreg(ADDR_IRQ_CTRL, k ? 8'h08 : 8'h02);
            idle(2);
            chk("irq_mask", {sec_irq, sw_irq}, 0);
            wreg(ADDR_IRQ_CTRL, 8'h00);
            rchk("irq_clr", ADDR_IRQ_CTRL, 8'h00);
        end
        wreg(ADDR_INT_OSC, 8'h75);
        for (int i = 0; i < 4; i++) begin
            slow_rdy <= i[1];
            fast_rdy <= i[0];
            idle(6);
            rchk("osc_rdy", ADDR_INT_OSC, osc_exp(8'h75));
        end
        wreg(3'h6, 8'hFF);
        rchk("unmapped6", 3'h6, 8'h00);
        rchk("unmapped7", 3'h7, 8'h00);
        stop_test();
    end
endmodule
`default_nettype wire
